// >>> hw/etsm_pkg.sv
// Package: constants and types of the elapsed timer state machine
package etsm_pkg;
    localparam int unsigned CLK_HZ = 10000000;
    localparam int unsigned TICK_CYCLES = CLK_HZ;
    localparam int unsigned CLEAR_HOLD_S = 3;
    localparam int unsigned TOTAL_HOLD_S = 10;
    localparam int unsigned MAX_REPEATS = 99;
    localparam int unsigned MAX_DELAY_S = 360000;
    localparam int unsigned TIME_W = 24;
    localparam int unsigned CYC_W = 7;
    localparam int unsigned GT_W = 32;
    localparam int unsigned GT_TENTH_S = 360;
    localparam logic [15:0] FW_VERSION = 16'h0100;

    // Offsets of the register map
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_TARGET = 8'h04;
    localparam logic [7:0] A_WAIT = 8'h08;
    localparam logic [7:0] A_REPEAT = 8'h0c;
    localparam logic [7:0] A_STATUS = 8'h10;
    localparam logic [7:0] A_UPPER = 8'h14;
    localparam logic [7:0] A_LOWER = 8'h18;
    localparam logic [7:0] A_GTOTAL = 8'h1c;

    // Fields of the control register
    localparam int unsigned C_DOWN = 0;
    localparam int unsigned C_REPEAT = 1;
    localparam int unsigned C_ENDLESS = 2;
    localparam int unsigned C_LOCAL = 3;
    localparam int unsigned C_PCLEAR = 4;
    localparam int unsigned C_TCLEAR = 5;
    localparam int unsigned C_EDIT = 6;
    localparam int unsigned C_LBLANK = 7;
    localparam int unsigned C_FMT = 8;
    localparam int unsigned C_STATOUT = 10;
    localparam logic [31:0] CTRL_RST = 32'h0000_0009;

    // Display formats
    localparam logic [1:0] FMT_HMS = 2'h0;
    localparam logic [1:0] FMT_HM = 2'h1;
    localparam logic [1:0] FMT_MS = 2'h2;
    localparam logic [1:0] FMT_UNIT = 2'h3;

    // Panel modes
    localparam logic [2:0] PM_DISPLAY = 3'h0;
    localparam logic [2:0] PM_TOTAL = 3'h1;
    localparam logic [2:0] PM_PROMPT = 3'h2;
    localparam logic [2:0] PM_EDIT = 3'h3;
    localparam logic [2:0] PM_CONFIG = 3'h4;
    localparam logic [2:0] PM_VERSION = 3'h5;

    typedef enum logic [2:0] {
        ST_RESET = 3'b000,
        ST_RUN = 3'b001,
        ST_DELAY = 3'b010,
        ST_PAUSE = 3'b011,
        ST_DONE = 3'b100
    } etsm_state_t;
endpackage

// >>> hw/etsm_sync.sv
// Two-stage synchroniser and rising-edge detector for panel and sensor inputs
`timescale 1ns/1ps
module etsm_sync (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Raw pin and results
    input wire logic pin,
    output logic level,
    output logic rise
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
    } etsm_sync_t;
    etsm_sync_t r_q, r_d;

    always_comb begin
        r_d = r_q;
        r_d.s1 = pin;
        r_d.s2 = r_q.s1;
        r_d.s3 = r_q.s2;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign level = r_q.s2;
    assign rise = r_q.s2 & ~r_q.s3;
endmodule

// >>> hw/etsm_tick.sv
// Seconds tick generator for the timer, grand total and chord holds
`timescale 1ns/1ps
module etsm_tick import etsm_pkg::*; #(
    parameter int unsigned TICK = TICK_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Tick output
    output logic tick
);
    typedef struct packed {
        logic [31:0] cnt;
        logic pulse;
    } etsm_tick_t;
    etsm_tick_t r_q, r_d;

    always_comb begin
        r_d = r_q;
        r_d.pulse = 1'b0;
        if (r_q.cnt >= 32'(TICK - 1)) begin
            r_d.cnt = '0;
            r_d.pulse = 1'b1;
        end else begin
            r_d.cnt = r_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_q <= '0;
        end else begin
            r_q <= r_d;
        end
    end

    assign tick = r_q.pulse;
endmodule

// >>> hw/etsm_top.sv
// Elapsed timer state machine with AHB-Lite registers and front panel logic
// Operation
// R1: With repeats on, run the period up to 99 times or without end.
// R2: Wait a programmable restart delay, up to 100 hours, between periods.
// R3: Count up from zero to target, or down from target to zero.
// R4: Pause and resume anywhere without changing the configured period.
// R5: E plus up shows grand total in tenths of an hour.
// R6: Held over ten seconds with clear enabled, prompt; yes plus E clears.
// R7: Both reset buttons over three seconds load zero or target, if enabled.
// R8: Panel start and stop buttons act only under local control.
// R9: P plus up edits target, and restart delay when repeats enabled.
// R10: P plus E enters configuration; P plus down shows firmware version.
// R11: Upper display shows elapsed time up, remaining time down.
// R12: Upper display formats hh:mm:ss, hh:mm, mm:ss or single unit.
// R13: Lower display shows target, or cycle totals with repeats, or blank.
// R14: Reset annunciator lit while count is being cleared or loaded.
// R15: Status lamp follows status output; total lamp follows total display.
// R16: Exactly five states; only defined events move between them.
// R17: Reset state holds count stopped at zero or target.
// R18: Start in reset or paused enters running toward target or zero; a pause entered from delay resumes to delay.
// R19: Stop in running or delay pauses; start returns to prior state.
// R20: Running enters delay on its own; delay expiry returns to running.
// R21: Starts come from input A or start button, stops from b or stop.
// R22: Running enters complete when no further cycles remain.
// R23: Period end goes to delay or complete; cycle counter steps per period.
// R24: Grand total advances while running and survives timer reset.
`timescale 1ns/1ps
module etsm_top import etsm_pkg::*; #(
    parameter int unsigned TICK = TICK_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Sensor inputs and panel buttons
    input wire logic sensor_a,
    input wire logic sensor_b,
    input wire logic btn_p,
    input wire logic btn_down,
    input wire logic btn_up,
    input wire logic btn_e,
    // Displays and annunciators
    output logic [TIME_W-1:0] upper_value,
    output logic [1:0] upper_format,
    output logic [15:0] lower_value,
    output logic lower_blank,
    output logic [2:0] panel_mode,
    output logic ann_reset,
    output logic ann_status,
    output logic ann_total,
    output logic status_out,
    output logic [2:0] timer_state
);
    localparam int unsigned NIN = 6;
    logic [NIN-1:0] raw, lvl, rise;
    logic tick;

    assign raw = {btn_e, btn_up, btn_down, btn_p, sensor_b, sensor_a};

    generate
        for (genvar i = 0; i < NIN; i++) begin : g_in
            etsm_sync u_sync (
                .hclk(hclk),
                .hresetn(hresetn),
                .pin(raw[i]),
                .level(lvl[i]),
                .rise(rise[i])
            );
        end
    endgenerate

    etsm_tick #(.TICK(TICK)) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick)
    );

    typedef struct packed {
        logic [31:0] ctrl;
        logic [TIME_W-1:0] target;
        logic [TIME_W-1:0] wait_t;
        logic [CYC_W-1:0] repeats;
        etsm_state_t st;
        etsm_state_t paused_from;
        logic [TIME_W-1:0] count;
        logic [TIME_W-1:0] wcount;
        logic [CYC_W-1:0] cycle;
        logic [GT_W-1:0] gt_sec;
        logic [GT_W-1:0] gt_tenths;
        logic [3:0] hold;
        logic [2:0] pmode;
        logic yes;
        logic clearing;
        logic ap_valid;
        logic ap_write;
        logic [7:0] ap_addr;
        logic sw_start;
        logic sw_stop;
        logic sw_clear;
        logic [31:0] rdata;
        logic [TIME_W-1:0] upper;
        logic [15:0] lower;
        logic lblank;
        logic ann_r;
        logic ann_t;
        logic stat;
    } etsm_top_t;
    etsm_top_t r_q, r_d;

    logic down, repeat_on, start_ev, stop_ev, chord_clear, chord_total, period_end;
    logic last_cycle;

    always_comb begin
        r_d = r_q;
        down = r_q.ctrl[C_DOWN];
        repeat_on = r_q.ctrl[C_REPEAT];
        r_d.sw_start = 1'b0;
        r_d.sw_stop = 1'b0;
        r_d.sw_clear = 1'b0;
        r_d.clearing = 1'b0;

        // Register bus: data phase follows the registered address phase
        if (r_q.ap_valid && r_q.ap_write) begin
            unique case (r_q.ap_addr)
                A_CTRL: r_d.ctrl = hwdata;
                A_TARGET: r_d.target = hwdata[TIME_W-1:0];
                A_WAIT: r_d.wait_t = (hwdata > 32'(MAX_DELAY_S)) ?
                    TIME_W'(MAX_DELAY_S) : hwdata[TIME_W-1:0]; // [R2]
                A_REPEAT: r_d.repeats = (hwdata > 32'(MAX_REPEATS)) ?
                    CYC_W'(MAX_REPEATS) : hwdata[CYC_W-1:0]; // [R1]
                A_STATUS: begin
                    r_d.sw_start = hwdata[0];
                    r_d.sw_stop = hwdata[1];
                    r_d.sw_clear = hwdata[2];
                end
                default: ;
            endcase
        end
        if (hsel && hready) begin
            r_d.ap_valid = htrans[1];
            r_d.ap_write = hwrite;
            r_d.ap_addr = haddr[7:0];
        end else if (hready) begin
            r_d.ap_valid = 1'b0;
        end
        if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                A_CTRL: r_d.rdata = r_q.ctrl;
                A_TARGET: r_d.rdata = 32'(r_q.target);
                A_WAIT: r_d.rdata = 32'(r_q.wait_t);
                A_REPEAT: r_d.rdata = 32'(r_q.repeats);
                A_STATUS: r_d.rdata = {5'h00, FW_VERSION, 1'b0, r_q.cycle, r_q.st};
                A_UPPER: r_d.rdata = 32'(r_q.count);
                A_LOWER: r_d.rdata = {16'h0000, r_q.lower};
                A_GTOTAL: r_d.rdata = r_q.gt_tenths;
                default: r_d.rdata = 32'h0000_0000;
            endcase
        end

        // Start and stop sources; panel buttons gated by local control
        start_ev = rise[0] | r_q.sw_start |
            (r_q.ctrl[C_LOCAL] & rise[3] & r_q.pmode == PM_DISPLAY); // [R8] [R21]
        stop_ev = rise[1] | r_q.sw_stop |
            (r_q.ctrl[C_LOCAL] & rise[4] & r_q.pmode == PM_DISPLAY); // [R8] [R21]

        // Chords: up+down resets, E+up shows total
        chord_clear = lvl[4] & lvl[3] & ~lvl[2] & ~lvl[5];
        chord_total = lvl[5] & lvl[4] & ~lvl[2];

        // Hold counter for timed chords
        if (chord_clear || chord_total) begin
            if (tick && r_q.hold != 4'hf) begin
                r_d.hold = r_q.hold + 4'h1;
            end
        end else begin
            r_d.hold = 4'h0;
        end

        // Panel mode
        unique case (r_q.pmode)
            PM_DISPLAY: begin
                if (chord_total) begin
                    r_d.pmode = PM_TOTAL; // [R5]
                end else if (lvl[2] && lvl[4] && r_q.ctrl[C_EDIT]) begin
                    r_d.pmode = PM_EDIT; // [R9]
                end else if (lvl[2] && lvl[5]) begin
                    r_d.pmode = PM_CONFIG; // [R10]
                end else if (lvl[2] && lvl[3]) begin
                    r_d.pmode = PM_VERSION; // [R10]
                end
            end
            PM_TOTAL: begin
                if (!chord_total) begin
                    r_d.pmode = PM_DISPLAY;
                end else if (r_q.hold >= 4'(TOTAL_HOLD_S) && r_q.ctrl[C_TCLEAR]) begin
                    r_d.pmode = PM_PROMPT; // [R6]
                    r_d.yes = 1'b0;
                end
            end
            PM_PROMPT: begin
                if (rise[4] || rise[3]) begin
                    r_d.yes = ~r_q.yes; // [R6]
                end
                if (rise[5]) begin
                    r_d.pmode = PM_DISPLAY;
                    if (r_q.yes) begin
                        r_d.gt_sec = '0; // [R6]
                        r_d.gt_tenths = '0;
                    end
                end
            end
            PM_EDIT, PM_CONFIG, PM_VERSION: begin
                // Left on the E button; software edits through the bus meanwhile
                if (rise[5] && !lvl[2]) begin
                    r_d.pmode = PM_DISPLAY;
                end
            end
            default: r_d.pmode = PM_DISPLAY;
        endcase

        // Period end and remaining cycles
        period_end = down ? (r_q.count == '0) : (r_q.count >= r_q.target);
        last_cycle = !repeat_on ||
            (!r_q.ctrl[C_ENDLESS] && r_q.cycle >= r_q.repeats); // [R1] [R22]

        // Timer states
        unique case (r_q.st)
            ST_RESET: begin
                r_d.count = down ? r_q.target : '0; // [R17]
                r_d.cycle = CYC_W'(1);
                if (start_ev) begin
                    r_d.st = ST_RUN; // [R18]
                end
            end
            ST_RUN: begin
                if (stop_ev) begin
                    r_d.st = ST_PAUSE; // [R19]
                    r_d.paused_from = ST_RUN;
                end else if (period_end) begin
                    if (last_cycle) begin
                        r_d.st = ST_DONE; // [R22] [R23]
                    end else begin
                        r_d.st = ST_DELAY; // [R20] [R23]
                        r_d.wcount = r_q.wait_t;
                    end
                end else if (tick) begin
                    r_d.count = down ? r_q.count - TIME_W'(1) : r_q.count + TIME_W'(1); // [R3]
                end
            end
            ST_DELAY: begin
                if (stop_ev) begin
                    r_d.st = ST_PAUSE; // [R19]
                    r_d.paused_from = ST_DELAY;
                end else if (r_q.wcount == '0) begin
                    r_d.st = ST_RUN; // [R20]
                    r_d.count = down ? r_q.target : '0;
                    if (r_q.cycle != CYC_W'(MAX_REPEATS) || !r_q.ctrl[C_ENDLESS]) begin
                        r_d.cycle = r_q.cycle + CYC_W'(1); // [R23]
                    end else begin
                        r_d.cycle = CYC_W'(1);
                    end
                end else if (tick) begin
                    r_d.wcount = r_q.wcount - TIME_W'(1); // [R2]
                end
            end
            ST_PAUSE: begin
                // Count and delay are frozen, so resume keeps the period intact
                if (start_ev) begin
                    r_d.st = r_q.paused_from; // [R4] [R19]
                end
            end
            ST_DONE: ;
            default: r_d.st = ST_RESET; // [R16]
        endcase

        // Timer clear from panel chord, or from software
        if ((chord_clear && r_q.ctrl[C_PCLEAR] && r_q.hold >= 4'(CLEAR_HOLD_S)) ||
                r_q.sw_clear) begin
            r_d.st = ST_RESET; // [R7]
            r_d.count = down ? r_q.target : '0; // [R7]
            r_d.clearing = 1'b1;
        end

        // Grand total runs on while running, kept across timer reset
        if (r_q.st == ST_RUN && tick) begin
            if (r_q.gt_sec >= GT_W'(GT_TENTH_S - 1)) begin
                r_d.gt_sec = '0;
                r_d.gt_tenths = r_q.gt_tenths + GT_W'(1); // [R24]
            end else begin
                r_d.gt_sec = r_q.gt_sec + GT_W'(1); // [R24]
            end
        end

        // Upper display and the reset and total lamps use next values so they never lag the state or panel mode
        if (r_d.pmode == PM_TOTAL || r_d.pmode == PM_PROMPT) begin
            r_d.upper = r_d.gt_tenths[TIME_W-1:0]; // [R5]
        end else begin
            r_d.upper = r_d.count; // [R11]
        end
        if (!repeat_on) begin
            r_d.lower = r_q.target[15:0]; // [R13]
        end else begin
            r_d.lower = {1'b0, r_q.repeats, 1'b0, r_q.cycle}; // [R13]
        end
        r_d.lblank = r_q.ctrl[C_LBLANK]; // [R13]
        r_d.ann_r = r_d.clearing || r_d.st == ST_RESET; // [R14]
        r_d.stat = r_q.ctrl[C_STATOUT];
        r_d.ann_t = r_d.pmode == PM_TOTAL || r_d.pmode == PM_PROMPT; // [R15]
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            r_q <= '0;
            r_q.ctrl <= CTRL_RST;
            r_q.st <= ST_RESET;
            r_q.ann_r <= 1'b1;
            r_q.paused_from <= ST_RUN;
            r_q.cycle <= CYC_W'(1);
            r_q.pmode <= PM_DISPLAY;
        end else begin
            r_q <= r_d;
        end
    end

    assign hrdata = r_q.rdata;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign upper_value = r_q.upper;
    assign upper_format = r_q.ctrl[C_FMT +: 2]; // [R12]
    assign lower_value = r_q.lower;
    assign lower_blank = r_q.lblank;
    assign panel_mode = r_q.pmode;
    assign ann_reset = r_q.ann_r;
    assign ann_status = r_q.stat; // [R15]
    assign ann_total = r_q.ann_t;
    assign status_out = r_q.stat; // [R15]
    assign timer_state = r_q.st;
endmodule

// >>> verification/etsm_monitor.sv
// Checker of the elapsed timer core at its top-level ports
`timescale 1ns/1ps
module etsm_monitor import etsm_pkg::*; #(
    parameter int unsigned TICK = TICK_CYCLES
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Observed outputs
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [TIME_W-1:0] upper_value,
    input wire logic [2:0] panel_mode,
    input wire logic ann_reset,
    input wire logic ann_status,
    input wire logic ann_total,
    input wire logic status_out,
    input wire logic [2:0] timer_state
);
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not okay");
    a_state_legal: assert property (timer_state <= 3'h4)
        else $error("state outside the five");
    a_reset_lamp: assert property (timer_state == 3'h0 |-> ann_reset)
        else $error("reset lamp dark");
    a_total_lamp: assert property (ann_total == (panel_mode inside {3'h1, 3'h2}))
        else $error("total lamp wrong");
    a_status_lamp: assert property (ann_status == status_out)
        else $error("status lamp wrong");
    // Count may only step by one second while running on the time display
    a_run_step: assert property (
        timer_state == 3'h1 && $past(timer_state) == 3'h1 && panel_mode == 3'h0
        && $past(panel_mode) == 3'h0
        |-> TIME_W'(upper_value - $past(upper_value)) inside {24'h0, 24'h1, 24'hffffff})
        else $error("count jumped while running");
    a_pause_hold: assert property (
        (timer_state == 3'h3 && panel_mode == 3'h0) [*2] |-> $stable(upper_value))
        else $error("count moved while paused");
    a_done_entry: assert property (
        $changed(timer_state) && timer_state == 3'h4 |-> $past(timer_state) == 3'h1)
        else $error("complete entered from wrong state");
    a_delay_entry: assert property (
        $changed(timer_state) && timer_state == 3'h2 |-> $past(timer_state) inside {3'h1, 3'h3})
        else $error("delay entered from wrong state");
    a_pause_entry: assert property (
        $changed(timer_state) && timer_state == 3'h3 |-> $past(timer_state) inside {3'h1, 3'h2})
        else $error("pause entered from wrong state");
    a_done_exit: assert property (
        $past(timer_state) == 3'h4 |-> timer_state inside {3'h0, 3'h4})
        else $error("complete left without reset");
endmodule
bind etsm_top etsm_monitor #(.TICK(TICK)) etsm_monitor_i (
    .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
    .upper_value(upper_value), .panel_mode(panel_mode), .ann_reset(ann_reset),
    .ann_status(ann_status), .ann_total(ann_total), .status_out(status_out),
    .timer_state(timer_state)
);

// >>> verification/etsm_panel.sv
// Model of the remote sensors and the four front panel buttons
`timescale 1ns/1ps
module etsm_panel (
    // Clock
    input wire logic hclk,
    // Lines into the timer
    output logic sensor_a,
    output logic sensor_b,
    output logic btn_p,
    output logic btn_down,
    output logic btn_up,
    output logic btn_e
);
    initial begin
        {sensor_a, sensor_b, btn_p, btn_down, btn_up, btn_e} = 6'h00;
    end
    // Lines are {a, b, p, down, up, e}; start comes from a, stop from b
    task automatic hold(input logic [5:0] lines, input int len);
        {sensor_a, sensor_b, btn_p, btn_down, btn_up, btn_e} <= lines;
        repeat (len) @(posedge hclk);
    endtask
    // Idle gap lets the synchroniser see a fresh rising edge next time
    task automatic pulse(input logic [5:0] lines, input int len);
        hold(lines, len);
        hold(6'h00, 4);
    endtask
endmodule

// >>> verification/tb.sv
// Testbench of the elapsed timer core
`timescale 1ns/1ps
module tb;
    import etsm_pkg::*;
    localparam int unsigned TK = 10;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, upper_format;
    logic [2:0] hsize, panel_mode, timer_state;
    logic [TIME_W-1:0] upper_value, held;
    logic [15:0] lower_value;
    logic lower_blank, ann_reset, ann_status, ann_total, status_out;
    logic sensor_a, sensor_b, btn_p, btn_down, btn_up, btn_e;
    int error_cnt, num_checks, cycles;
    etsm_top #(.TICK(TK)) etsm_top_i (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sensor_a(sensor_a),
        .sensor_b(sensor_b), .btn_p(btn_p), .btn_down(btn_down), .btn_up(btn_up),
        .btn_e(btn_e), .upper_value(upper_value), .upper_format(upper_format),
        .lower_value(lower_value), .lower_blank(lower_blank), .panel_mode(panel_mode),
        .ann_reset(ann_reset), .ann_status(ann_status), .ann_total(ann_total),
        .status_out(status_out), .timer_state(timer_state)
    );
    etsm_panel etsm_panel_i (
        .hclk(hclk), .sensor_a(sensor_a), .sensor_b(sensor_b), .btn_p(btn_p),
        .btn_down(btn_down), .btn_up(btn_up), .btn_e(btn_e)
    );
    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            $display("[ERR] %0t cycle limit reached", $time);
            end_sim();
        end
    end
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge hclk);
    endtask
    // Zero-wait slave, yet the master still waits on hready as the bus demands
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd,
            output logic [31:0] rd);
        {hsel, hwrite, haddr, htrans, hsize} <= {1'b1, w, 24'h0, a, 2'h2, 3'h2};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        {hsel, htrans} <= 3'h0;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        bus(1'b0, a, 32'h0, x);
        chk(x, e);
    endtask
    task automatic st(input logic [2:0] s, input int max);
        int n = 0;
        while (timer_state !== s && n < max) begin
            @(posedge hclk);
            n++;
        end
        chk({29'h0, timer_state}, {29'h0, s});
    endtask
    task automatic pl(input logic [5:0] k, input int n);
        etsm_panel_i.pulse(k, n);
    endtask
    task automatic t_reset();
        st(3'h0, 0);
        rd_chk(A_UPPER, 32'h0);
        rd_chk(A_CTRL, CTRL_RST);
        wr(A_UPPER, 32'h55);
        rd_chk(A_UPPER, 32'h0);
        wr(8'h40, 32'hffffffff);
        rd_chk(8'h40, 32'h0);
        $display("test reset finished");
    endtask
    task automatic t_down();
        wr(A_CTRL, 32'h9);
        wr(A_TARGET, 32'h5);
        wr(A_STATUS, 32'h4);
        cyc(3);
        chk({8'h0, upper_value}, 32'h5);
        chk({31'h0, ann_reset}, 32'h1);
        chk({16'h0, lower_value}, 32'h5);
        wr(A_STATUS, 32'h1);
        st(3'h1, 6);
        st(3'h4, 80);
        chk({8'h0, upper_value}, 32'h0);
        $display("test down finished");
    endtask
    task automatic t_pause();
        wr(A_CTRL, 32'h8);
        wr(A_TARGET, 32'h6);
        wr(A_STATUS, 32'h4);
        st(3'h0, 6);
        wr(A_STATUS, 32'h1);
        cyc(25);
        wr(A_STATUS, 32'h2);
        st(3'h3, 6);
        held = upper_value;
        cyc(30);
        chk({8'h0, upper_value}, {8'h0, held});
        wr(A_STATUS, 32'h1);
        st(3'h1, 6);
        st(3'h4, 80);
        chk({8'h0, upper_value}, 32'h6);
        $display("test pause finished");
    endtask
    task automatic t_repeat();
        wr(A_CTRL, 32'ha);
        wr(A_TARGET, 32'h3);
        wr(A_REPEAT, 32'hc8);
        rd_chk(A_REPEAT, 32'h63);
        wr(A_WAIT, 32'h61a80);
        rd_chk(A_WAIT, 32'h57e40);
        wr(A_WAIT, 32'h2);
        wr(A_REPEAT, 32'h2);
        wr(A_STATUS, 32'h4);
        wr(A_STATUS, 32'h1);
        st(3'h2, 60);
        wr(A_STATUS, 32'h2);
        st(3'h3, 6);
        wr(A_STATUS, 32'h1);
        st(3'h2, 6);
        st(3'h1, 40);
        st(3'h4, 60);
        chk({16'h0, lower_value}, 32'h0202);
        wr(A_CTRL, 32'he);
        wr(A_REPEAT, 32'h1);
        wr(A_STATUS, 32'h4);
        wr(A_STATUS, 32'h1);
        cyc(90);
        chk({31'h0, timer_state == 3'h4}, 32'h0);
        $display("test repeat finished");
    endtask
    task automatic t_sensor();
        wr(A_CTRL, 32'h0);
        wr(A_TARGET, 32'hc8);
        wr(A_STATUS, 32'h4);
        pl(6'h02, 3);
        st(3'h0, 0);
        pl(6'h20, 3);
        st(3'h1, 8);
        pl(6'h04, 3);
        st(3'h1, 0);
        pl(6'h10, 3);
        st(3'h3, 8);
        wr(A_CTRL, 32'h8);
        pl(6'h04, 3);
        st(3'h1, 8);
        pl(6'h02, 3);
        st(3'h3, 8);
        $display("test sensor finished");
    endtask
    task automatic t_total();
        wr(A_CTRL, 32'h28);
        wr(A_TARGET, 32'h1000);
        wr(A_STATUS, 32'h4);
        wr(A_STATUS, 32'h1);
        cyc(3700);
        wr(A_STATUS, 32'h2);
        st(3'h3, 6);
        rd_chk(A_GTOTAL, 32'h1);
        wr(A_STATUS, 32'h4);
        wr(A_CTRL, 32'h20);
        st(3'h0, 6);
        rd_chk(A_GTOTAL, 32'h1);
        etsm_panel_i.hold(6'h03, 20);
        chk({29'h0, panel_mode}, {29'h0, PM_TOTAL});
        chk({31'h0, ann_total}, 32'h1);
        chk({8'h0, upper_value}, 32'h1);
        etsm_panel_i.hold(6'h03, 100);
        chk({29'h0, panel_mode}, {29'h0, PM_PROMPT});
        etsm_panel_i.hold(6'h00, 4);
        pl(6'h04, 3);
        pl(6'h01, 3);
        rd_chk(A_GTOTAL, 32'h0);
        $display("test total finished");
    endtask
    task automatic t_panel();
        logic [5:0] keys [3] = '{6'h0c, 6'h09, 6'h0a};
        logic [2:0] mode [3] = '{PM_VERSION, PM_CONFIG, PM_EDIT};
        wr(A_CTRL, 32'h4a);
        for (int i = 0; i < 3; i++) begin
            pl(keys[i], 3);
            chk({29'h0, panel_mode}, {29'h0, mode[i]});
            pl(6'h01, 3);
            chk({29'h0, panel_mode}, 32'h0);
        end
        wr(A_CTRL, 32'h18);
        wr(A_STATUS, 32'h1);
        cyc(30);
        etsm_panel_i.hold(6'h06, 45);
        st(3'h0, 0);
        chk({8'h0, upper_value}, 32'h0);
        chk({31'h0, ann_reset}, 32'h1);
        etsm_panel_i.hold(6'h00, 4);
        for (int f = 0; f < 4; f++) begin
            wr(A_CTRL, 32'h8 | 32'(f << 8));
            cyc(3);
            chk({30'h0, upper_format}, 32'(f));
        end
        wr(A_CTRL, 32'h488);
        cyc(3);
        chk({30'h0, status_out, ann_status}, 32'h3);
        chk({31'h0, lower_blank}, 32'h1);
        $display("test panel finished");
    endtask
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, haddr, hwdata, htrans, hsize} = '0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_reset();
        t_down();
        t_pause();
        t_repeat();
        t_sensor();
        t_total();
        t_panel();
        end_sim();
    end
endmodule
